// ===== src/smp_defines.vh
// Register map, field positions and reset values of the synchronous serial port
`ifndef SMP_DEFINES_VH
`define SMP_DEFINES_VH

// Register indices on the plain register port
`define SMP_ADDR_W        3
`define SMP_REG_TXSTAT    3'h0
`define SMP_REG_RXSTAT    3'h1
`define SMP_REG_BAUD      3'h2
`define SMP_REG_TXHOLD    3'h3
`define SMP_REG_RXDATA    3'h4
`define SMP_REG_IRQEN     3'h5
`define SMP_REG_IRQFLAG   3'h6

// transmit_status_control fields
`define SMP_TX_CLKSRC     7
`define SMP_TX_NINE       6
`define SMP_TX_EN         5
`define SMP_TX_SYNC       4
`define SMP_TX_HISPEED    2
`define SMP_TX_EMPTY      1
`define SMP_TX_NINTHBIT   0
`define SMP_TXSTAT_RST    8'h02

// receive_status_control fields
`define SMP_RX_PORTEN     7
`define SMP_RX_NINE       6
`define SMP_RX_SINGLE     5
`define SMP_RX_CONT       4
`define SMP_RX_ADDRDET    3
`define SMP_RX_FRAMING    2
`define SMP_RX_OVERRUN    1
`define SMP_RX_NINTHBIT   0
`define SMP_RXSTAT_RST    8'h00

// peripheral_irq_flags_1 fields
`define SMP_IF_RECEIVE    5
`define SMP_IF_TRANSMIT   4

`define SMP_BAUD_RST      8'h00
`define SMP_IRQEN_RST     8'h00
`define SMP_TXHOLD_RST    8'h00

// Shift clock phases per data bit and receive FIFO depth
`define SMP_PHASES        4
`define SMP_FIFO_DEPTH    2

`endif

// ===== src/smp_serial_port.v
// Synchronous serial port: master/slave shift engine, baud timer, receive FIFO, registers

`include "smp_defines.vh"

module smp_serial_port #(
	parameter DATA_W = 8
) (
	// Clock and reset
	input  wire              clk,
	input  wire              rst_n,
	// Register port
	input  wire [`SMP_ADDR_W-1:0] regAddr,
	input  wire [DATA_W-1:0] regWdata,
	input  wire              regWr,
	input  wire              regRd,
	output reg  [DATA_W-1:0] regRdata,
	// Clock pin
	input  wire              ckIn,
	output reg               ckOut,
	output reg               ckOe,
	// Data pin
	input  wire              dtIn,
	output reg               dtOut,
	output reg               dtOe
);

	localparam ST_IDLE = 3'b001;
	localparam ST_TX   = 3'b010;
	localparam ST_RX   = 3'b100;

	// Control registers
	reg  [7:0]        txStat_q;
	reg               portEn_q;
	reg               rxNine_q;
	reg               rxSingle_q;
	reg               rxCont_q;
	reg               addrDet_q;
	reg               overrun_q;
	reg  [7:0]        baud_q;
	reg  [7:0]        irqEn_q;
	reg  [7:0]        txHold_q;
	reg               txFull_q;
	// Engine
	reg  [2:0]        state_q;
	reg  [7:0]        baudCnt_q;
	reg  [1:0]        phase_q;
	reg  [3:0]        bitCnt_q;
	reg  [8:0]        txShift_q;
	reg  [8:0]        rxShift_q;
	reg               nineCur_q;
	// Receive FIFO
	reg  [8:0]        fifoMem [0:`SMP_FIFO_DEPTH-1];
	reg               rdPtr_q;
	reg               wrPtr_q;
	reg  [1:0]        count_q;
	// Pin synchronisers
	reg               ckMeta_q;
	reg               ckSync_q;
	reg               ckPrev_q;
	reg               dtMeta_q;
	reg               dtSync_q;

	wire syncMode  = txStat_q[`SMP_TX_SYNC];
	wire master    = syncMode & txStat_q[`SMP_TX_CLKSRC] & portEn_q;
	wire slave     = syncMode & ~txStat_q[`SMP_TX_CLKSRC] & portEn_q;
	wire active    = master | slave;
	wire rxMode    = rxSingle_q | rxCont_q;
	wire txMode    = ~rxMode & txStat_q[`SMP_TX_EN];
	// High-speed select only reads back, the engine ignores it: synchronous rate is fixed at four phases per bit
	wire tick      = (baudCnt_q == 8'h00);
	wire mLead     = master & tick & (phase_q == 2'd0);
	wire mTrail    = master & tick & (phase_q == 2'd2);
	// Engine may leave idle at any phase; a trailing tick before the first
	// leading edge of a character is not a bit, and counting it would drop
	// the last bit and cut the character one clock short
	wire mTrailLive = mTrail & ckOut;
	// Slave edges lag the pin by three clocks through the synchroniser, so the
	// external shift clock must stay well below a sixth of the system clock
	wire sLead     = slave & ckSync_q & ~ckPrev_q;
	wire sTrail    = slave & ~ckSync_q & ckPrev_q;
	wire lead      = mLead | sLead;
	wire trail     = mTrailLive | sTrail;
	wire lastBit   = (bitCnt_q == (nineCur_q ? 4'd8 : 4'd7));
	wire fifoFull  = (count_q == `SMP_FIFO_DEPTH);
	wire rdData    = regRd & (regAddr == `SMP_REG_RXDATA);
	wire pop       = rdData & (count_q != 2'd0);
	wire wrTxHold  = regWr & (regAddr == `SMP_REG_TXHOLD);
	wire wrRxStat  = regWr & (regAddr == `SMP_REG_RXSTAT);
	wire rxDone    = (state_q == ST_RX) & trail & lastBit;
	wire push      = rxDone & ~fifoFull;
	wire [8:0] topEntry = fifoMem[rdPtr_q];

	function [7:0] rd_mux;
		input [`SMP_ADDR_W-1:0] a;
		input [7:0] txs;
		input [7:0] rxs;
		input [7:0] bd;
		input [7:0] ie;
		input [7:0] top;
		input       rcvFlag;
		input       xmtFlag;
		begin
			case (a)
				`SMP_REG_TXSTAT:  rd_mux = txs;
				`SMP_REG_RXSTAT:  rd_mux = rxs;
				`SMP_REG_BAUD:    rd_mux = bd;
				`SMP_REG_RXDATA:  rd_mux = top;
				`SMP_REG_IRQEN:   rd_mux = ie;
				`SMP_REG_IRQFLAG: rd_mux = {2'b00, rcvFlag, xmtFlag, 4'h0};
				default:          rd_mux = 8'h00;
			endcase
		end
	endfunction

	// Pin synchronisers; first stage feeds only the second
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ckMeta_q <= 1'b0;
			ckSync_q <= 1'b0;
			ckPrev_q <= 1'b0;
			dtMeta_q <= 1'b0;
			dtSync_q <= 1'b0;
		end else begin
			ckMeta_q <= ckIn;
			ckSync_q <= ckMeta_q;
			ckPrev_q <= ckSync_q;
			dtMeta_q <= dtIn;
			dtSync_q <= dtMeta_q;
		end
	end

	// Baud timer: reload on underflow, restart on baud write
	// Limitation: baud value 0 leaves two clocks from leading edge to sampling,
	// which the data pin synchroniser uses up entirely
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baudCnt_q <= `SMP_BAUD_RST;
			phase_q   <= 2'd0;
		end else if (regWr && regAddr == `SMP_REG_BAUD) begin
			baudCnt_q <= regWdata[7:0];
			phase_q   <= 2'd0;
		end else if (tick) begin
			baudCnt_q <= baud_q;
			phase_q   <= phase_q + 2'd1;
		end else begin
			baudCnt_q <= baudCnt_q - 8'h01;
		end
	end

	// Registers and control bits
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txStat_q   <= `SMP_TXSTAT_RST;
			portEn_q   <= 1'b0;
			rxNine_q   <= 1'b0;
			rxSingle_q <= 1'b0;
			rxCont_q   <= 1'b0;
			addrDet_q  <= 1'b0;
			overrun_q  <= 1'b0;
			baud_q     <= `SMP_BAUD_RST;
			irqEn_q    <= `SMP_IRQEN_RST;
			txHold_q   <= `SMP_TXHOLD_RST;
			txFull_q   <= 1'b0;
			regRdata   <= 8'h00;
		end else begin
			regRdata <= regRd ? rd_mux(regAddr,
				{txStat_q[7:2], ~(state_q == ST_TX), txStat_q[0]},
				{portEn_q, rxNine_q, rxSingle_q, rxCont_q, addrDet_q, 1'b0,
				 overrun_q, topEntry[8]},
				baud_q, irqEn_q, topEntry[7:0],
				(count_q != 2'd0), ~txFull_q) : 8'h00;
			if (regWr) begin
				case (regAddr)
					`SMP_REG_TXSTAT: txStat_q <= {regWdata[7:4], 1'b0, regWdata[2], 1'b1,
						regWdata[0]};
					`SMP_REG_BAUD:   baud_q <= regWdata[7:0];
					`SMP_REG_IRQEN:  irqEn_q <= regWdata[7:0];
					`SMP_REG_RXSTAT: begin
						portEn_q   <= regWdata[`SMP_RX_PORTEN];
						rxNine_q   <= regWdata[`SMP_RX_NINE];
						rxSingle_q <= regWdata[`SMP_RX_SINGLE];
						rxCont_q   <= regWdata[`SMP_RX_CONT];
						addrDet_q  <= regWdata[`SMP_RX_ADDRDET];
					end
					default: ;
				endcase
			end
			// Hardware clear of single receive beats a same-cycle software write
			if (rxDone && rxSingle_q)
				rxSingle_q <= 1'b0;
			// Holding register: filled by software, emptied by the shifter load
			if (wrTxHold) begin
				txHold_q <= regWdata[7:0];
				txFull_q <= 1'b1;
			end else if (state_q == ST_IDLE && active && txMode && txFull_q) begin
				txFull_q <= 1'b0;
			end
			// Overrun: set wins over every clear
			if (rxDone && fifoFull)
				overrun_q <= 1'b1;
			else if (rdData && !rxCont_q)
				overrun_q <= 1'b0;
			else if (wrRxStat && (!regWdata[`SMP_RX_CONT] || !regWdata[`SMP_RX_PORTEN]))
				overrun_q <= 1'b0;
			// Port disable holds the port in reset
			if (!portEn_q) begin
				overrun_q  <= 1'b0;
				txFull_q   <= wrTxHold;
				rxSingle_q <= wrRxStat & regWdata[`SMP_RX_SINGLE];
			end
		end
	end

	// Shift engine
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= ST_IDLE;
			bitCnt_q  <= 4'd0;
			txShift_q <= 9'h000;
			rxShift_q <= 9'h000;
			nineCur_q <= 1'b0;
			ckOut     <= 1'b0;
			ckOe      <= 1'b0;
			dtOut     <= 1'b0;
			dtOe      <= 1'b0;
		end else begin
			ckOe <= master;
			dtOe <= active & txMode;
			if (!active) begin
				state_q <= ST_IDLE;
				ckOut   <= 1'b0;
			end else begin
				case (state_q)
					ST_IDLE: begin
						bitCnt_q <= 4'd0;
						ckOut    <= 1'b0;
						if (txMode && txFull_q) begin
							txShift_q <= {txStat_q[`SMP_TX_NINTHBIT], txHold_q};
							nineCur_q <= txStat_q[`SMP_TX_NINE];
							state_q   <= ST_TX;
						end else if (rxMode && !overrun_q) begin
							nineCur_q <= rxNine_q;
							rxShift_q <= 9'h000;
							state_q   <= ST_RX;
						end
					end
					ST_TX: begin
						if (lead) begin
							dtOut     <= txShift_q[0];
							txShift_q <= {1'b0, txShift_q[8:1]};
						end
						if (mLead)
							ckOut <= 1'b1;
						if (mTrail)
							ckOut <= 1'b0;
						if (trail) begin
							bitCnt_q <= bitCnt_q + 4'd1;
							if (lastBit)
								state_q <= ST_IDLE;
						end
					end
					ST_RX: begin
						if (!rxMode) begin
							state_q <= ST_IDLE;
							ckOut   <= 1'b0;
						end else begin
							if (mLead)
								ckOut <= 1'b1;
							if (mTrail)
								ckOut <= 1'b0;
							if (trail) begin
								rxShift_q[bitCnt_q] <= dtSync_q;
								bitCnt_q <= bitCnt_q + 4'd1;
								if (lastBit)
									state_q <= ST_IDLE;
							end
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// Receive FIFO; a full character lands with the bit sampled this edge
	// On overrun both entries are kept and the third character is dropped
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdPtr_q    <= 1'b0;
			wrPtr_q    <= 1'b0;
			count_q    <= 2'd0;
			fifoMem[0] <= 9'h000;
			fifoMem[1] <= 9'h000;
		end else if (!portEn_q) begin
			rdPtr_q <= 1'b0;
			wrPtr_q <= 1'b0;
			count_q <= 2'd0;
		end else begin
			if (push) begin
				fifoMem[wrPtr_q] <= nineCur_q ? {dtSync_q, rxShift_q[7:0]} :
					{1'b0, dtSync_q, rxShift_q[6:0]};
				wrPtr_q <= ~wrPtr_q;
			end
			if (pop)
				rdPtr_q <= ~rdPtr_q;
			case ({push, pop})
				2'b10:   count_q <= count_q + 2'd1;
				2'b01:   count_q <= count_q - 2'd1;
				default: count_q <= count_q;
			endcase
		end
	end

endmodule // smp_serial_port

// ===== tb/smp_serial_port_props.sv
// Checker for the serial port register port and pins
`include "smp_defines.vh"
module smp_serial_port_props (
	// Clock and reset
	input logic       clk,
	input logic       rst_n,
	// Register port
	input logic [2:0] regAddr,
	input logic [7:0] regWdata,
	input logic       regWr,
	input logic       regRd,
	input logic [7:0] regRdata,
	// Pins
	input logic       ckIn,
	input logic       ckOut,
	input logic       ckOe,
	input logic       dtIn,
	input logic       dtOut,
	input logic       dtOe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  baudQ;
	logic        portQ;
	logic        mstQ;
	logic [15:0] gapQ;
	wire         wrTx = regWr && regAddr == `SMP_REG_TXSTAT;
	wire         wrRx = regWr && regAddr == `SMP_REG_RXSTAT;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baudQ <= 8'h00;
			portQ <= 1'b0;
			mstQ  <= 1'b0;
			gapQ  <= 16'hffff;
		end else begin
			if (regWr && regAddr == `SMP_REG_BAUD)
				baudQ <= regWdata;
			if (wrRx)
				portQ <= regWdata[`SMP_RX_PORTEN];
			if (wrTx)
				mstQ <= regWdata[`SMP_TX_CLKSRC];
			// Saturates so long idle gaps never wrap
			if ($rose(ckOut))
				gapQ <= 16'h0001;
			else if (gapQ != 16'hffff)
				gapQ <= gapQ + 16'h0001;
		end
	end
	sequence s_mstCfg;
		wrTx && regWdata[`SMP_TX_CLKSRC] && regWdata[`SMP_TX_SYNC] && regWdata[`SMP_TX_EN] && portQ;
	endsequence
	property p_master; s_mstCfg |-> ##2 ckOe; endproperty
	property p_slave; wrTx && !regWdata[`SMP_TX_CLKSRC] |-> ##2 !ckOe; endproperty
	property p_rxNoDrv;
		wrRx && regWdata[`SMP_RX_PORTEN] && regWdata[`SMP_RX_CONT] |-> ##2 !dtOe;
	endproperty
	property p_ckDrv; ckOut |-> ckOe; endproperty
	property p_dtDrv; dtOe && mstQ && $past(mstQ, 2) |-> ckOe; endproperty
	property p_dtEdge; dtOe && $past(dtOe) && $changed(dtOut) |-> $rose(ckOut); endproperty
	property p_rate; $rose(ckOut) |-> gapQ >= 4 * (baudQ + 1); endproperty
	property p_txhRd; regRd && regAddr == `SMP_REG_TXHOLD |=> regRdata == 8'h00; endproperty
	a_master: assert property (p_master) else $error("clock driver off as master");
	a_slave: assert property (p_slave) else $error("clock driven as slave");
	a_rxNoDrv: assert property (p_rxNoDrv) else $error("data driven in receive");
	a_ckDrv: assert property (p_ckDrv) else $error("clock high while undriven");
	a_dtDrv: assert property (p_dtDrv) else $error("data driven without clock");
	a_dtEdge: assert property (p_dtEdge) else $error("data moved off leading edge");
	a_rate: assert property (p_rate) else $error("bit period too short");
	a_txhRd: assert property (p_txhRd) else $error("holding register readable");
endmodule // smp_serial_port_props

bind smp_serial_port smp_serial_port_props smp_serial_port_props_inst (.clk(clk), .rst_n(rst_n),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.ckIn(ckIn), .ckOut(ckOut), .ckOe(ckOe), .dtIn(dtIn), .dtOut(dtOut), .dtOe(dtOe));

// ===== tb/smp_slave_model.sv
// Behavioural slave on the far side of the clock and data pins
module smp_slave_model (
	// Pins
	input  wire        ckLine,
	input  wire        dtLine,
	output logic       dtDrv,
	// Test control
	input  wire        clr,
	input  wire  [8:0] sendWord,
	output logic [8:0] gotWord,
	output int         bitCnt
);
	timeunit 1ns;
	timeprecision 1ps;
	initial dtDrv = 1'b0;
	// Next bit on each leading edge, held until the next one
	always @(posedge ckLine)
		dtDrv <= sendWord[bitCnt % 9];
	always @(negedge ckLine or posedge clr)
		if (clr) begin
			gotWord <= 9'h000;
			bitCnt  <= 0;
		end else begin
			gotWord <= {dtLine, gotWord[8:1]};
			bitCnt  <= bitCnt + 1;
		end
endmodule // smp_slave_model

// ===== tb/tb_top.sv
// Testbench for the synchronous serial port as master
`include "smp_defines.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED %0t got %h", $time, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, mClr = 1'b0;
	logic       ckOut, ckOe, dtOut, dtOe, mDt;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWdata = 8'h00, regRdata;
	logic [8:0] mSend = 9'h000, mGot;
	int         mCnt, err_total = 0, checks = 0, cyc = 0;
	time        t0;
	wire        ckLine = ckOe & ckOut;
	wire        dtLine = dtOe ? dtOut : mDt;
	smp_serial_port smp_serial_port_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ckIn(ckLine),
		.ckOut(ckOut), .ckOe(ckOe), .dtIn(dtLine), .dtOut(dtOut), .dtOe(dtOe));
	smp_slave_model smp_slave_model_inst (.ckLine(ckLine), .dtLine(dtLine), .dtDrv(mDt),
		.clr(mClr), .sendWord(mSend), .gotWord(mGot), .bitCnt(mCnt));
	initial forever #4 clk = ~clk;
	// Strobe stays up so back-to-back writes never drive it twice in one step
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		regWr   <= 1'b0;
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 `CHK(regRdata, e)
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk);
			regWr <= 1'b0;
		end
	endtask
	task automatic waitB(input int n);
		while (mCnt < n) idle(1);
	endtask
	task automatic clrM(input logic [8:0] w);
		@(posedge clk);
		mClr  <= 1'b1;
		mSend <= w;
		@(posedge clk);
		mClr <= 1'b0;
	endtask
	task automatic t_regs;
		rd(`SMP_REG_TXSTAT, `SMP_TXSTAT_RST);
		rd(`SMP_REG_RXSTAT, `SMP_RXSTAT_RST);
		rd(`SMP_REG_BAUD, `SMP_BAUD_RST);
		rd(3'h7, 8'h00);
		wr(`SMP_REG_IRQEN, 8'h30);
		rd(`SMP_REG_IRQEN, 8'h30);
	endtask
	task automatic t_tx;
		clrM(9'h000);
		wr(`SMP_REG_BAUD, 8'h01);
		wr(`SMP_REG_RXSTAT, 8'h80);
		wr(`SMP_REG_TXSTAT, 8'hb0);
		wr(`SMP_REG_TXHOLD, 8'ha5);
		wr(`SMP_REG_TXHOLD, 8'h3c);
		waitB(1);
		t0 = $time;
		waitB(2);
		`CHK($time - t0, 64'd64)
		waitB(8);
		`CHK(mGot[8:1], 8'ha5)
		rd(`SMP_REG_TXHOLD, 8'h00);
		waitB(16);
		idle(40);
		`CHK(mCnt, 16)
		`CHK(mGot[8:1], 8'h3c)
		wr(`SMP_REG_TXSTAT, 8'hf1);
		wr(`SMP_REG_TXHOLD, 8'h5a);
		waitB(25);
		idle(40);
		`CHK(mGot, 9'h15a)
		`CHK(mCnt, 25)
		rd(`SMP_REG_TXSTAT, 8'hf3);
	endtask
	task automatic t_rxOne;
		clrM(9'h0c3);
		wr(`SMP_REG_RXSTAT, 8'ha0);
		waitB(8);
		idle(40);
		`CHK(mCnt, 8)
		rd(`SMP_REG_RXSTAT, 8'h80);
		rd(`SMP_REG_IRQFLAG, 8'h30);
		rd(`SMP_REG_RXDATA, 8'hc3);
		rd(`SMP_REG_IRQFLAG, 8'h10);
	endtask
	task automatic t_rxCont;
		clrM(9'h196);
		wr(`SMP_REG_RXSTAT, 8'hd0);
		waitB(27);
		idle(20);
		rd(`SMP_REG_RXSTAT, 8'hd3);
		rd(`SMP_REG_RXDATA, 8'h96);
		rd(`SMP_REG_RXSTAT, 8'hd3);
		wr(`SMP_REG_RXSTAT, 8'hc0);
		rd(`SMP_REG_RXSTAT, 8'hc1);
		rd(`SMP_REG_RXDATA, 8'h96);
		rd(`SMP_REG_IRQFLAG, 8'h10);
	endtask
	task automatic t_abort;
		clrM(9'h0ff);
		wr(`SMP_REG_RXSTAT, 8'h90);
		waitB(3);
		wr(`SMP_REG_RXSTAT, 8'h80);
		idle(40);
		`CHK(mCnt < 5, 1'b1)
		rd(`SMP_REG_IRQFLAG, 8'h10);
	endtask
	task automatic t_both;
		clrM(9'h0a5);
		wr(`SMP_REG_RXSTAT, 8'hb0);
		waitB(9);
		rd(`SMP_REG_RXSTAT, 8'h90);
		wr(`SMP_REG_RXSTAT, 8'h80);
		idle(4);
		rd(`SMP_REG_RXDATA, 8'ha5);
		rd(`SMP_REG_IRQFLAG, 8'h10);
	endtask
	task automatic t_slave;
		wr(`SMP_REG_TXSTAT, 8'h30);
		idle(4);
		`CHK(ckOe, 1'b0)
	endtask
	task automatic summarize;
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_tx;
		t_rxOne;
		t_rxCont;
		t_abort;
		t_both;
		t_slave;
		summarize;
	end
endmodule // tb_top
